//--- logic/sacr_pkg.sv
// package for the auxiliary sensor configuration register bank
// assumes a register access port with 9-bit word address and 16-bit data
package sacr_pkg;

   // ----------------------------------------
   // register addresses
   // ----------------------------------------
   localparam logic [8:0] SACR_CP_CFG_ADDR   = 9'h048;
   localparam logic [8:0] SACR_SPARE_A_ADDR  = 9'h050;
   localparam logic [8:0] SACR_SPARE_B_ADDR  = 9'h051;
   localparam logic [8:0] SACR_TD_EN_ADDR    = 9'h060;
   localparam logic [8:0] SACR_TD_RES_ADDR   = 9'h061;
   localparam logic [8:0] SACR_SER_PWR_ADDR  = 9'h070;
   localparam logic [8:0] SACR_BLK_CFG_ADDR  = 9'h080;
   localparam logic [8:0] SACR_DP_CFG_ADDR   = 9'h081;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [15:0] SACR_CP_CFG_RST   = 16'h1200;
   localparam logic [15:0] SACR_SPARE_A_RST  = 16'h0000;
   localparam logic [15:0] SACR_SPARE_B_RST  = 16'h0000;
   localparam logic [15:0] SACR_TD_EN_RST    = 16'h0000;
   localparam logic [15:0] SACR_SER_PWR_RST  = 16'h0000;
   localparam logic [15:0] SACR_BLK_CFG_RST  = 16'h4008;
   localparam logic [15:0] SACR_DP_CFG_RST   = 16'hC001;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int SACR_CP_PD_EN_BIT   = 0;
   localparam int SACR_CP_FD_EN_BIT   = 1;
   localparam int SACR_CP_PD_TRIM_LSB = 8;
   localparam int SACR_CP_FD_TRIM_LSB = 12;
   localparam int SACR_TRIM_W         = 3;
   localparam int SACR_TD_EN_BIT      = 0;
   localparam int SACR_TEMP_W         = 8;
   localparam int SACR_SER_CLK_BIT    = 0;
   localparam int SACR_SER_SYNC_BIT   = 1;
   localparam int SACR_SER_DATA_BIT   = 2;
   localparam int SACR_DATA_CH_N      = 4;
   localparam int SACR_BLK_LVL_LSB    = 0;
   localparam int SACR_BLK_LVL_W      = 8;
   localparam int SACR_BLK_SMP_LSB    = 8;
   localparam int SACR_BLK_SMP_W      = 3;
   localparam int SACR_CRC_SEED_BIT   = 15;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [8:0]  addr;
      logic [15:0] wdata;
   } sacr_req_t;

   typedef struct packed {
      logic                        pd_pump_en;
      logic                        fd_pump_en;
      logic [SACR_TRIM_W-1:0]      pd_trim;
      logic [SACR_TRIM_W-1:0]      fd_trim;
      logic                        temp_diode_en;
      logic                        ser_clk_pwr_up;
      logic                        ser_sync_pwr_up;
      logic [SACR_DATA_CH_N-1:0]   ser_data_pwr_up;
      logic [SACR_BLK_LVL_W-1:0]   black_target;
      logic [SACR_BLK_SMP_W-1:0]   black_samples_log2;
      logic [7:0]                  black_sample_cnt;
      logic                        crc_seed_ones;
      logic [15:0]                 data_path_cfg;
   } sacr_ctl_t;

endpackage : sacr_pkg

//--- logic/sacr_regs.sv
// auxiliary sensor configuration register bank: pumps, temp diode, serializer, data block
// assumes a single-clock register port from the serial programming interface decoder
//
// Behaviour
// RL1: transfer charge pump enabled only while charge pump bit 0 is one; resets zero.
// RL2: floating diffusion pump enabled only while charge pump bit 1 is one; resets zero.
// RL3: transfer trim in bits 10:8 resets 2; diffusion trim in 14:12 resets 1.
// RL4: temp diode enabled by enable bit 0; result read as 8 bits.
// RL5: serializer clock output powered up only while power bit 0 is one.
// RL6: sync channel powered up only while power bit 1 is one.
// RL7: all four data channels powered up together only by power bit 2.
// RL8: black level bits 7:0 are the target output black level; resets 8.
// RL9: black samples averaged equal two to the power of bits 10:8.
// RL10: crc starts all zeros when bit 15 is zero, all ones when one.
// RL11: reserved registers and fields store writes, read back, no side effects.
`timescale 1ns/1ps
`default_nettype none

module sacr_regs
(
   // clock and reset
   input  wire logic                             sys_clk,
   input  wire logic                             rst,
   // register access port
   input  wire sacr_pkg::sacr_req_t              req,
   output logic [15:0]                           rdata,
   output logic                                  rvalid,
   // temperature readout from the diode converter
   input  wire logic [sacr_pkg::SACR_TEMP_W-1:0] temp_code,
   // analog and datapath controls
   output sacr_pkg::sacr_ctl_t                   ctl
);
   import sacr_pkg::*;

   // ----------------------------------------
   // storage
   // ----------------------------------------
   logic [15:0]            cp_cfg_r;
   logic [15:0]            spare_a_r;
   logic [15:0]            spare_b_r;
   logic [15:0]            td_en_r;
   logic [15:0]            ser_pwr_r;
   logic [15:0]            blk_cfg_r;
   logic [15:0]            dp_cfg_r;
   logic [SACR_TEMP_W-1:0] temp_s1_r;
   logic [SACR_TEMP_W-1:0] temp_s2_r;
   logic [SACR_TEMP_W-1:0] temp_s3_r;
   logic [SACR_TEMP_W-1:0] temp_hold_r;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire logic sel_cp  = req.addr == SACR_CP_CFG_ADDR;
   wire logic sel_sa  = req.addr == SACR_SPARE_A_ADDR;
   wire logic sel_sb  = req.addr == SACR_SPARE_B_ADDR;
   wire logic sel_te  = req.addr == SACR_TD_EN_ADDR;
   wire logic sel_tr  = req.addr == SACR_TD_RES_ADDR;
   wire logic sel_sp  = req.addr == SACR_SER_PWR_ADDR;
   wire logic sel_bc  = req.addr == SACR_BLK_CFG_ADDR;
   wire logic sel_dp  = req.addr == SACR_DP_CFG_ADDR;

   // ----------------------------------------
   // write enables
   // ----------------------------------------
   // the result word and unmapped addresses have no enable, so their writes drop
   wire logic we_cp   = req.wr && sel_cp;
   wire logic we_sa   = req.wr && sel_sa;
   wire logic we_sb   = req.wr && sel_sb;
   wire logic we_te   = req.wr && sel_te;
   wire logic we_sp   = req.wr && sel_sp;
   wire logic we_bc   = req.wr && sel_bc;
   wire logic we_dp   = req.wr && sel_dp;

   // result word: converter code in the low byte, upper byte reads zero
   wire logic [15:0] temp_word = {{(16-SACR_TEMP_W){1'b0}}, temp_hold_r}; // [RL4]

   wire logic [15:0] rd_mux =
        sel_cp ? cp_cfg_r  :
        sel_sa ? spare_a_r :                                           // [RL11]
        sel_sb ? spare_b_r :                                           // [RL11]
        sel_te ? td_en_r   :
        sel_tr ? temp_word :
        sel_sp ? ser_pwr_r :
        sel_bc ? blk_cfg_r :
        sel_dp ? dp_cfg_r  : 16'h0000;

   // ----------------------------------------
   // control decode
   // ----------------------------------------
   sacr_ctl_t ctl_nxt;
   wire logic [SACR_BLK_SMP_W-1:0] smp_log2 =
        blk_cfg_r[SACR_BLK_SMP_LSB +: SACR_BLK_SMP_W];

   // one power-up line per data channel, all from the same bit
   wire logic [SACR_DATA_CH_N-1:0] data_ch_up;
   for (genvar ch = 0; ch < SACR_DATA_CH_N; ch++) begin : g_data_ch
      assign data_ch_up[ch] = ser_pwr_r[SACR_SER_DATA_BIT];                  // [RL7]
   end

   always_comb begin
      ctl_nxt                    = '0;
      ctl_nxt.pd_pump_en         = cp_cfg_r[SACR_CP_PD_EN_BIT];                 // [RL1]
      ctl_nxt.fd_pump_en         = cp_cfg_r[SACR_CP_FD_EN_BIT];                 // [RL2]
      ctl_nxt.pd_trim            = cp_cfg_r[SACR_CP_PD_TRIM_LSB +: SACR_TRIM_W]; // [RL3]
      ctl_nxt.fd_trim            = cp_cfg_r[SACR_CP_FD_TRIM_LSB +: SACR_TRIM_W]; // [RL3]
      ctl_nxt.temp_diode_en      = td_en_r[SACR_TD_EN_BIT];                     // [RL4]
      ctl_nxt.ser_clk_pwr_up     = ser_pwr_r[SACR_SER_CLK_BIT];                 // [RL5]
      ctl_nxt.ser_sync_pwr_up    = ser_pwr_r[SACR_SER_SYNC_BIT];                // [RL6]
      ctl_nxt.ser_data_pwr_up    = data_ch_up;                                  // [RL7]
      ctl_nxt.black_target       = blk_cfg_r[SACR_BLK_LVL_LSB +: SACR_BLK_LVL_W]; // [RL8]
      ctl_nxt.black_samples_log2 = smp_log2;                                    // [RL9]
      ctl_nxt.black_sample_cnt   = 8'h01 << smp_log2;                           // [RL9]
      ctl_nxt.crc_seed_ones      = blk_cfg_r[SACR_CRC_SEED_BIT];                // [RL10]
      ctl_nxt.data_path_cfg      = dp_cfg_r;
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   // one short process per stored word, whole 16 bits kept
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cp_cfg_r <= SACR_CP_CFG_RST;                                 // [RL1] [RL2] [RL3]
      end else if (we_cp) begin
         cp_cfg_r <= req.wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         spare_a_r <= SACR_SPARE_A_RST;
      end else if (we_sa) begin
         spare_a_r <= req.wdata;                                      // [RL11]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         spare_b_r <= SACR_SPARE_B_RST;
      end else if (we_sb) begin
         spare_b_r <= req.wdata;                                      // [RL11]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         td_en_r <= SACR_TD_EN_RST;                                   // [RL4]
      end else if (we_te) begin
         td_en_r <= req.wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ser_pwr_r <= SACR_SER_PWR_RST;                               // [RL5]
      end else if (we_sp) begin
         ser_pwr_r <= req.wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         blk_cfg_r <= SACR_BLK_CFG_RST;                               // [RL8] [RL9] [RL10]
      end else if (we_bc) begin
         blk_cfg_r <= req.wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dp_cfg_r <= SACR_DP_CFG_RST;
      end else if (we_dp) begin
         dp_cfg_r <= req.wdata;
      end
   end

   // ----------------------------------------
   // temperature sync
   // ----------------------------------------
   // converter word is asynchronous: two flops per bit, then a word is taken
   // only when two samples in a row agree, so a torn word never reaches the bus
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         temp_s1_r   <= '0;
         temp_s2_r   <= '0;
         temp_s3_r   <= '0;
         temp_hold_r <= '0;
      end else begin
         temp_s1_r <= temp_code;
         temp_s2_r <= temp_s1_r;
         temp_s3_r <= temp_s2_r;
         if (temp_s2_r == temp_s3_r) begin
            temp_hold_r <= temp_s2_r;                                 // [RL4]
         end
      end
   end

   // ----------------------------------------
   // read answer
   // ----------------------------------------
   // idle cycles and unmapped addresses answer zero
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdata  <= 16'h0000;
         rvalid <= 1'b0;
      end else begin
         rdata  <= req.rd ? rd_mux : 16'h0000;
         rvalid <= req.rd;
      end
   end

   // ----------------------------------------
   // control outputs
   // ----------------------------------------
   // held at zero through reset so pumps and output channels stay off
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctl <= '0;
      end else begin
         ctl <= ctl_nxt;
      end
   end

endmodule : sacr_regs

`default_nettype wire

//--- verif/sacr_monitor.sv
// checker for the sacr_regs register bank
// assumes it is bound onto the sacr_regs ports
`timescale 1ns/1ps
`default_nettype none
module sacr_monitor
   import sacr_pkg::*;
(
   // watched ports
   input wire logic                          sys_clk,
   input wire logic                          rst,
   input wire sacr_pkg::sacr_req_t           req,
   input wire logic [15:0]                   rdata,
   input wire logic                          rvalid,
   input wire logic [sacr_pkg::SACR_TEMP_W-1:0] temp_code,
   input wire sacr_pkg::sacr_ctl_t           ctl
);
   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire logic [15:0] w      = req.wdata;
   wire logic        wr_cp  = req.wr && req.addr == SACR_CP_CFG_ADDR;
   wire logic        wr_td  = req.wr && req.addr == SACR_TD_EN_ADDR;
   wire logic        wr_ser = req.wr && req.addr == SACR_SER_PWR_ADDR;
   wire logic        wr_blk = req.wr && req.addr == SACR_BLK_CFG_ADDR;
   // cycles since reset, saturating; the temperature path is refilled after four
   logic [2:0]       run_cnt_r;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         run_cnt_r <= 3'h0;
      end else if (run_cnt_r != 3'h7) begin
         run_cnt_r <= run_cnt_r + 3'h1;
      end
   end
   chk_pump_enables: assert property (wr_cp |-> ##2 {ctl.fd_pump_en, ctl.pd_pump_en} ==
      $past(w[1:0], 2)) else $error("pump enables wrong");
   chk_pump_trims: assert property (wr_cp |=> ##1 ctl.pd_trim == $past(w[10:8], 2) &&
      ctl.fd_trim == $past(w[14:12], 2)) else $error("pump trims wrong");
   chk_temp_enable: assert property (wr_td |-> ##2 ctl.temp_diode_en == $past(w[0], 2))
      else $error("temp diode enable wrong");
   chk_ser_clk_sync: assert property (wr_ser |-> ##2 {ctl.ser_sync_pwr_up,
      ctl.ser_clk_pwr_up} == $past(w[1:0], 2)) else $error("serializer clock or sync wrong");
   chk_ser_data_all: assert property (wr_ser |-> ##2 ctl.ser_data_pwr_up ==
      {4{$past(w[2], 2)}}) else $error("data channels not together");
   chk_black_count: assert property (wr_blk |-> ##2 ctl.black_target == $past(w[7:0], 2) &&
      ctl.black_sample_cnt == 8'h01 << $past(w[10:8], 2)) else $error("black level wrong");
   chk_crc_seed: assert property (wr_blk |-> ##2 ctl.crc_seed_ones == $past(w[15], 2))
      else $error("crc seed wrong");
   chk_read_pulse: assert property (rvalid == ($past(req.rd) && !$past(rst)))
      else $error("read answer pulse wrong");
   chk_temp_readout: assert property (req.rd && req.addr == SACR_TD_RES_ADDR &&
      run_cnt_r == 3'h7 && $past(temp_code, 3) == $past(temp_code, 4) |=>
      rdata == {8'h00, $past(temp_code, 4)}) else $error("temperature readout wrong");
   cover property (req.rd && req.addr == SACR_SPARE_A_ADDR ##1 rvalid);
   cover property (wr_blk ##2 ctl.crc_seed_ones);
   cover property (wr_ser ##2 ctl.ser_data_pwr_up == 4'hF);
   cover property (req.rd && req.addr == SACR_TD_RES_ADDR);
endmodule : sacr_monitor
bind sacr_regs sacr_monitor i_mon (.sys_clk(sys_clk), .rst(rst), .req(req), .rdata(rdata),
   .rvalid(rvalid), .temp_code(temp_code), .ctl(ctl));
`default_nettype wire

//--- verif/tb_sacr_regs.sv
// self-checking bench for sacr_regs
// assumes sacr_pkg compiled and sacr_monitor bound
`timescale 1ns/1ps
`default_nettype none
module tb_sacr_regs;
   import sacr_pkg::*;
   // ----------------------------------------
   // stimulus and checks
   // ----------------------------------------
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   sacr_req_t   req = '0;
   logic [7:0]  temp_code = 8'h00;
   logic [15:0] rdata;
   logic        rvalid;
   sacr_ctl_t   ctl;
   int          n_errors = 0;
   int          n_tests = 0;
   localparam logic [8:0] ADR [8] = '{9'h048, 9'h050, 9'h051, 9'h060, 9'h061, 9'h070, 9'h080,
      9'h081};
   localparam logic [15:0] RV [8] = '{16'h1200, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h4008, 16'hC001};
   sacr_regs i_dut (.sys_clk(sys_clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
      .temp_code(temp_code), .ctl(ctl));
   initial begin
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic r, input logic [8:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      #1 req = '{w, r, a, d};
      @(posedge sys_clk);
      #1 req = '0;
   endtask : xfer
   task automatic rd(input logic [8:0] a, input logic [15:0] exp);
      xfer(1'b0, 1'b1, a, 16'h0000);
      chk(16'(rvalid), 16'h0001);
      chk(rdata, exp);
   endtask : rd
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      xfer(1'b1, 1'b0, a, d);
      @(posedge sys_clk);
      #1;
   endtask : wr
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out
   task automatic check_defaults;
      for (int i = 0; i < 8; i++) begin
         rd(ADR[i], RV[i]);
      end
      chk(16'({ctl.fd_trim, ctl.pd_trim}), 16'h000A);
      chk(16'({ctl.black_target, ctl.black_sample_cnt}), 16'h0801);
      chk(16'(ctl.black_samples_log2), 16'h0000);
      chk(16'({ctl.fd_pump_en, ctl.pd_pump_en}), 16'h0000);
      chk(16'(ctl.temp_diode_en), 16'h0000);
      chk(16'({ctl.ser_sync_pwr_up, ctl.ser_clk_pwr_up}), 16'h0000);
      chk(16'(ctl.ser_data_pwr_up), 16'h0000);
      chk(16'(ctl.crc_seed_ones), 16'h0000);
   endtask : check_defaults
   initial begin
      repeat (12) @(posedge sys_clk);
      #1 rst = 1'b0;
      check_defaults();
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         wr(9'h048, 16'h7700 | 16'(i));
         chk(16'({ctl.fd_pump_en, ctl.pd_pump_en}), 16'(i));
      end
      chk(16'({ctl.fd_trim, ctl.pd_trim}), 16'h003F);
      for (int i = 0; i < 8; i++) begin
         wr(9'h070, 16'(i));
         chk(16'({ctl.ser_data_pwr_up, ctl.ser_sync_pwr_up, ctl.ser_clk_pwr_up}),
            16'({{4{i[2]}}, i[1:0]}));
      end
      $display("test pumps and serializer done");
      wr(9'h060, 16'h0001);
      chk(16'(ctl.temp_diode_en), 16'h0001);
      wr(9'h060, 16'hFFFE);
      chk(16'(ctl.temp_diode_en), 16'h0000);
      rd(9'h060, 16'hFFFE);
      temp_code = 8'h3C;
      wr(9'h061, 16'hFFFF);
      rd(9'h061, 16'h003C);
      $display("test temperature done");
      for (int j = 0; j < 8; j++) begin
         wr(9'h080, {1'b1, 4'h0, 3'(j), 8'(j + 16)});
         chk(16'({ctl.crc_seed_ones, ctl.black_target}), 16'(j + 272));
         chk(16'(ctl.black_sample_cnt), 16'h0001 << j);
         chk(16'(ctl.black_samples_log2), 16'(j));
      end
      wr(9'h080, 16'h4008);
      chk(16'(ctl.crc_seed_ones), 16'h0000);
      wr(9'h050, 16'hFFFF);
      wr(9'h051, 16'hA5A5);
      wr(9'h081, 16'h1234);
      wr(9'h1FF, 16'hFFFF);
      rd(9'h050, 16'hFFFF);
      rd(9'h051, 16'hA5A5);
      rd(9'h1FF, 16'h0000);
      chk(ctl.data_path_cfg, 16'h1234);
      $display("test black level and reserved done");
      temp_code = 8'h00;
      @(posedge sys_clk);
      #1 rst = 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 rst = 1'b0;
      check_defaults();
      $display("test mid-run reset done");
      close_out();
   end
endmodule : tb_sacr_regs
`default_nettype wire
